// ===== src/conversion_sequence_config.sv
module conversion_sequence_config
    import conv_seq_pkg::*;
#(
    parameter int SHORT_CYC  = INTERVAL_SHORT_CYC,   // shorten for simulation
    parameter int MEDIUM_CYC = INTERVAL_MEDIUM_CYC,
    parameter int LONG_CYC   = INTERVAL_LONG_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,              // command byte
    input  wire logic       reg_write,             // one-cycle write strobe
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,             // follows reg_addr one cycle later
    input  wire logic       conv_done,             // converter finished the channel
    output logic            conv_start,            // one-cycle pulse per channel
    output logic [2:0]      conv_channel,          // 0 local, 1..4 remote
    output logic            busy,
    output logic            soft_standby,
    output logic            remote4_queue_enable,
    output logic            remote3_queue_enable,
    output logic [1:0]      interval_select
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0] config_bits;   // main_configuration
        logic [7:0] interval_bits; // conversion_interval
        logic [7:0] enable_bits;   // channel_enable_mask
        logic       shot_pending;  // one-shot request not yet started
        logic       shot_active;   // running sequence is a one-shot
        seq_state_t seq;
        logic [2:0] channel;       // channel under test
        logic       conv_start;
        logic [7:0] rdata;
        logic       busy;
    } ctrl_t;

    ctrl_t state_reg;   // registered state
    ctrl_t state_next;  // next state

    logic timer_restart;  // start of a new interval
    logic timer_expired;  // interval over

    // masked write: only the defined bits move
    function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
        masked = data & mask;
    endfunction : masked

    // ****************************************************************
    // interval timer
    // ****************************************************************
    interval_timer #(
        .SHORT_CYC  (SHORT_CYC),
        .MEDIUM_CYC (MEDIUM_CYC),
        .LONG_CYC   (LONG_CYC)
    ) u_timer (
        .clk             (clk),
        .rst             (rst),
        .restart         (timer_restart),
        .interval_select (state_reg.interval_bits[1:0]),
        .expired         (timer_expired)
    );

    // restart whenever a sequence leaves idle
    always_comb begin
        timer_restart = (state_reg.seq == SEQ_IDLE) && (state_next.seq == SEQ_PICK);
    end

    // ****************************************************************
    // register file and sequencer
    // ****************************************************************
    always_comb begin
        logic       standby;
        logic       found;
        logic [2:0] pick;
        standby = 1'b0;
        found   = 1'b0;
        pick    = 3'h0;
        state_next            = state_reg;
        state_next.conv_start = 1'b0;
        standby               = state_reg.config_bits[BIT_SOFT_STANDBY];

        // register writes; reserved bits are dropped
        if (reg_write) begin
            unique case (reg_addr)
                ADDR_MAIN_CONFIGURATION:
                    state_next.config_bits = masked(reg_wdata, CONFIG_WRITE_MASK);
                ADDR_CONVERSION_INTERVAL:
                    state_next.interval_bits = masked(reg_wdata, INTERVAL_WRITE_MASK);
                ADDR_CHANNEL_ENABLE_MASK:
                    state_next.enable_bits = masked(reg_wdata, ENABLE_WRITE_MASK);
                ADDR_ONE_SHOT: begin
                    // data is thrown away; ignored outside standby
                    if (standby) begin
                        state_next.shot_pending = 1'b1;
                    end
                end
                default: begin
                    // read-only or unmapped: nothing stored
                end
            endcase
        end

        // lowest enabled channel at or above the current one
        for (int i = NUM_CHANNELS - 1; i >= 0; i--) begin
            if (state_reg.enable_bits[i] && (3'(i) >= state_reg.channel)) begin
                found = 1'b1;
                pick  = 3'(i);
            end
        end

        unique case (state_reg.seq)
            SEQ_IDLE: begin
                state_next.channel = 3'h0;
                if (!standby) begin
                    state_next.seq = SEQ_PICK; // active: free running
                    // a request left over from standby must not fire later
                    state_next.shot_pending = 1'b0;
                end else if (state_reg.shot_pending) begin
                    // a one-shot starts one sequence
                    state_next.seq          = SEQ_PICK;
                    state_next.shot_active  = 1'b1;
                    state_next.shot_pending = reg_write && (reg_addr == ADDR_ONE_SHOT);
                end
            end
            SEQ_PICK: begin
                if (standby && !state_reg.shot_active) begin
                    // standby arrived between channels: stop cleanly
                    state_next.seq = SEQ_IDLE;
                end else if (found) begin
                    state_next.channel    = pick;
                    state_next.conv_start = 1'b1; // channels one after another
                    state_next.seq        = SEQ_CONVERT;
                end else if (state_reg.shot_active) begin
                    state_next.shot_active = 1'b0; // back to standby
                    state_next.seq         = SEQ_IDLE;
                end else if (state_reg.interval_bits[1:0] == RATE_CONTINUOUS) begin
                    state_next.seq = SEQ_IDLE; // continuous: sequence just shorter
                end else begin
                    state_next.seq = SEQ_WAIT; // standby for the remainder
                end
            end
            SEQ_CONVERT: begin
                // current channel always completes, even under standby
                if (conv_done) begin
                    state_next.channel = state_reg.channel + 3'h1;
                    state_next.seq     = SEQ_PICK;
                end
            end
            SEQ_WAIT: begin
                // standby set during the wait ends it early; no conversion lost
                if (timer_expired || standby) begin
                    state_next.seq = SEQ_IDLE;
                end
            end
        endcase

        state_next.busy = (state_next.seq == SEQ_PICK) || (state_next.seq == SEQ_CONVERT);

        // read mux; undefined bits are zero
        unique case (reg_addr)
            ADDR_COMMON_STATUS:
                state_next.rdata = {state_reg.busy, 7'h00};
            ADDR_MAIN_CONFIGURATION:
                state_next.rdata = masked(state_reg.config_bits, CONFIG_WRITE_MASK);
            ADDR_CONVERSION_INTERVAL:
                state_next.rdata = masked(state_reg.interval_bits, INTERVAL_WRITE_MASK);
            ADDR_CHANNEL_ENABLE_MASK:
                state_next.rdata = masked(state_reg.enable_bits, ENABLE_WRITE_MASK);
            default:
                state_next.rdata = 8'h00;
        endcase
    end

    // register the state; defaults at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '{config_bits:   CONFIG_RESET,
                           interval_bits: INTERVAL_RESET,
                           enable_bits:   ENABLE_RESET,
                           shot_pending:  1'b0,
                           shot_active:   1'b0,
                           seq:           SEQ_IDLE,
                           channel:       3'h0,
                           conv_start:    1'b0,
                           rdata:         8'h00,
                           busy:          1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************************************
    // outputs, all straight from the state register
    // ****************************************************************
    assign reg_rdata            = state_reg.rdata;
    assign conv_start           = state_reg.conv_start;
    assign conv_channel         = state_reg.channel;
    assign busy                 = state_reg.busy;
    assign soft_standby         = state_reg.config_bits[BIT_SOFT_STANDBY];
    assign remote4_queue_enable = state_reg.config_bits[BIT_REMOTE4_QUEUE];
    assign remote3_queue_enable = state_reg.config_bits[BIT_REMOTE3_QUEUE];
    assign interval_select      = state_reg.interval_bits[1:0];

endmodule : conversion_sequence_config

// ===== src/conv_seq_pkg.sv
package conv_seq_pkg;

    // ****************************************************************
    // register command bytes
    // ****************************************************************
    localparam logic [7:0] ADDR_COMMON_STATUS      = 8'h02; // busy flag lives here
    localparam logic [7:0] ADDR_MAIN_CONFIGURATION = 8'h03;
    localparam logic [7:0] ADDR_CONVERSION_INTERVAL = 8'h04;
    localparam logic [7:0] ADDR_CHANNEL_ENABLE_MASK = 8'h05;
    localparam logic [7:0] ADDR_ONE_SHOT           = 8'h0f; // write only, data dropped

    // ****************************************************************
    // field positions and reset values
    // ****************************************************************
    localparam int         BIT_SOFT_STANDBY   = 6;
    localparam int         BIT_REMOTE4_QUEUE  = 1;
    localparam int         BIT_REMOTE3_QUEUE  = 0;
    localparam int         BIT_BUSY           = 7;
    localparam logic [7:0] CONFIG_WRITE_MASK  = 8'h43; // bits 6, 1, 0
    localparam logic [7:0] INTERVAL_WRITE_MASK = 8'h03; // bits 1..0
    localparam logic [7:0] ENABLE_WRITE_MASK  = 8'h1f; // bits 4..0
    localparam logic [7:0] CONFIG_RESET       = 8'h03;
    localparam logic [7:0] INTERVAL_RESET     = 8'h02;
    localparam logic [7:0] ENABLE_RESET       = 8'h1f;

    // ****************************************************************
    // channels and interval encodings
    // ****************************************************************
    localparam int         NUM_CHANNELS       = 5;      // local, remote 1..4
    localparam logic [1:0] RATE_CONTINUOUS    = 2'h0;
    localparam logic [1:0] RATE_SHORT         = 2'h1;
    localparam logic [1:0] RATE_MEDIUM        = 2'h2;
    localparam logic [1:0] RATE_LONG          = 2'h3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int CLK_FREQ_MHZ      = 50;
    localparam int INTERVAL_SHORT_US  = 364000;   // 0.364 s
    localparam int INTERVAL_MEDIUM_US = 1000000;  // 1 s
    localparam int INTERVAL_LONG_US   = 2500000;  // 2.5 s
    localparam int INTERVAL_SHORT_CYC  = INTERVAL_SHORT_US * CLK_FREQ_MHZ;
    localparam int INTERVAL_MEDIUM_CYC = INTERVAL_MEDIUM_US * CLK_FREQ_MHZ;
    localparam int INTERVAL_LONG_CYC   = INTERVAL_LONG_US * CLK_FREQ_MHZ;

    // sequencer states
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_PICK,
        SEQ_CONVERT,
        SEQ_WAIT
    } seq_state_t;

endpackage : conv_seq_pkg

// ===== src/interval_timer.sv
module interval_timer
    import conv_seq_pkg::*;
#(
    parameter int SHORT_CYC  = INTERVAL_SHORT_CYC,
    parameter int MEDIUM_CYC = INTERVAL_MEDIUM_CYC,
    parameter int LONG_CYC   = INTERVAL_LONG_CYC
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       restart,          // one-cycle pulse at sequence start
    input  wire logic [1:0] interval_select,
    output logic            expired
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [31:0] count;    // cycles left in this interval
        logic        expired;  // interval used up
    } timer_t;

    timer_t state_reg;   // registered state
    timer_t state_next;  // next state

    // chosen interval length in cycles, minus the restart cycle
    function automatic logic [31:0] load_value(input logic [1:0] sel);
        unique case (sel)
            RATE_SHORT:  load_value = 32'(SHORT_CYC - 1);
            RATE_MEDIUM: load_value = 32'(MEDIUM_CYC - 1);
            RATE_LONG:   load_value = 32'(LONG_CYC - 1);
            RATE_CONTINUOUS: load_value = 32'h0000_0000; // continuous: no wait
        endcase
    endfunction : load_value

    // ****************************************************************
    // countdown; the whole interval is timed from the sequence start, so
    // skipped channels simply leave more standby time at the end
    // ****************************************************************
    always_comb begin
        state_next = state_reg;
        if (restart) begin
            state_next.count   = load_value(interval_select);
            state_next.expired = (load_value(interval_select) == 32'h0000_0000);
        end else if (state_reg.count != 32'h0000_0000) begin
            state_next.count   = state_reg.count - 32'h0000_0001;
            state_next.expired = (state_reg.count == 32'h0000_0001);
        end
    end

    // register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= '{count: 32'h0000_0000, expired: 1'b1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign expired = state_reg.expired;

endmodule : interval_timer

// ===== bench/conv_seq_monitor.sv
// ****************************************************************
// port checker for the sequencer
// ****************************************************************
module conv_seq_monitor
    import conv_seq_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       conv_done,
    input wire logic       conv_start,
    input wire logic [2:0] conv_channel,
    input wire logic       busy,
    input wire logic       soft_standby,
    input wire logic       remote4_queue_enable,
    input wire logic       remote3_queue_enable,
    input wire logic [1:0] interval_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // config write lands on the outputs one edge later
    a_standby_write: assert property (reg_write && reg_addr == ADDR_MAIN_CONFIGURATION |=>
        soft_standby == $past(reg_wdata[BIT_SOFT_STANDBY])) else $error("standby bit wrong");
    a_queue4_write: assert property (reg_write && reg_addr == ADDR_MAIN_CONFIGURATION |=>
        remote4_queue_enable == $past(reg_wdata[1])) else $error("queue 4 bit wrong");
    a_queue3_write: assert property (reg_write && reg_addr == ADDR_MAIN_CONFIGURATION |=>
        remote3_queue_enable == $past(reg_wdata[0])) else $error("queue 3 bit wrong");
    a_interval_write: assert property (reg_write && reg_addr == ADDR_CONVERSION_INTERVAL |=>
        interval_select == $past(reg_wdata[1:0])) else $error("interval field wrong");
    // readback skips the first edge after reset, the mux still held zero
    a_config_readback: assert property (!$past(rst) && $past(reg_addr) == 8'h03 |->
        reg_rdata == {1'b0, $past(soft_standby), 4'h0, $past(remote4_queue_enable),
        $past(remote3_queue_enable)}) else $error("config readback wrong");
    a_interval_readback: assert property (!$past(rst) && $past(reg_addr) == 8'h04 |->
        reg_rdata == {6'h00, $past(interval_select)}) else $error("interval readback wrong");
    a_oneshot_zero: assert property ($past(reg_addr) == ADDR_ONE_SHOT |->
        reg_rdata == 8'h00) else $error("one-shot reads nonzero");
    a_start_single_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    a_busy_at_start: assert property (conv_start |-> busy && $past(busy))
        else $error("start without busy");
    a_channel_legal: assert property (conv_start |-> conv_channel < 3'h5)
        else $error("channel out of range");
endmodule : conv_seq_monitor

bind conversion_sequence_config conv_seq_monitor u_mon (.clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .conv_done(conv_done), .conv_start(conv_start),
    .conv_channel(conv_channel), .busy(busy), .soft_standby(soft_standby),
    .remote4_queue_enable(remote4_queue_enable),
    .remote3_queue_enable(remote3_queue_enable), .interval_select(interval_select));

// ===== bench/conv_model.sv
// ****************************************************************
// converter stand-in: answers each start after a fixed delay
// ****************************************************************
module conv_model #(
    parameter int DELAY = 3 // larger value models a slow converter
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic conv_start,
    output logic      conv_done
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt; // cycles left in the running conversion
    // done is a single pulse, low otherwise so a stale level never leaks
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt       <= 0;
            conv_done <= 1'b0;
        end else begin
            conv_done <= (cnt == 1);
            if (conv_start) cnt <= DELAY;
            else if (cnt > 0) cnt <= cnt - 1;
        end
    end
endmodule : conv_model

// ===== bench/conversion_sequence_config_tb_top.sv
module conversion_sequence_config_tb_top import conv_seq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // signals
    // ****************************************************************
    logic clk = 1'b0, rst = 1'b1, reg_write = 1'b0, conv_done, conv_start, busy;
    logic soft_standby, remote4_queue_enable, remote3_queue_enable;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
    logic [2:0] conv_channel;
    logic [1:0] interval_select;
    logic [2:0] chans[$];         // channel log in start order
    int n_errors = 0, n_checks = 0;
    int cyc = 0, last0 = 0, period = 0, n_start = 0, n_done = 0;
    int iv[4] = '{0, 200, 400, 800}; // shortened intervals given to the design
    always #10 clk = ~clk;
    conversion_sequence_config #(.SHORT_CYC(200), .MEDIUM_CYC(400), .LONG_CYC(800)) u_dut (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .conv_start(conv_start), .conv_channel(conv_channel), .busy(busy),
        .soft_standby(soft_standby), .remote4_queue_enable(remote4_queue_enable),
        .remote3_queue_enable(remote3_queue_enable), .interval_select(interval_select));
    conv_model #(.DELAY(3)) u_conv (.clk(clk), .rst(rst), .conv_start(conv_start),
        .conv_done(conv_done));
    // log starts; period is measured between local channel starts
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (conv_done === 1'b1) n_done <= n_done + 1;
        if (conv_start === 1'b1) begin
            chans.push_back(conv_channel);
            n_start <= n_start + 1;
            if (conv_channel === 3'h0) begin
                period <= cyc - last0;
                last0  <= cyc;
            end
        end
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic end_sim();
        if (n_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(posedge clk);
        #1 reg_write = 1'b0;
    endtask : wr
    // readback one edge after the address is applied
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 reg_addr = a;
        @(posedge clk);
        #1 chk(32'(reg_rdata), 32'(exp));
    endtask : rd
    task automatic wait_idle();
        int i;
        // step past the edge so the registered flag has settled
        for (i = 0; i < 5000 && busy !== 1'b0; i++) begin
            @(posedge clk);
            #1;
        end
        if (busy !== 1'b0) begin
            n_errors++;
            end_sim();
        end
    endtask : wait_idle
    task automatic wait_starts(input int n);
        int k;
        k = n_start + n;
        // step past the edge so the start counter has settled
        for (int i = 0; i < 20000 && n_start < k; i++) begin
            @(posedge clk);
            #1;
        end
        if (n_start < k) begin
            n_errors++;
            end_sim();
        end
        #1;
    endtask : wait_starts
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        rd(8'h03, 8'h03);
        rd(8'h04, 8'h02);
        rd(8'h05, 8'h1f);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'h03);
        wr(8'h05, 8'he0);
        rd(8'h05, 8'h00);
        wr(8'h05, 8'hff);
        wr(8'h03, 8'hbc);
        rd(8'h03, 8'h00);
        wr(8'h07, 8'h55);
        rd(8'h07, 8'h00);
        rd(8'h0f, 8'h00);
        // standby: the running channel ends and nothing more starts
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h43);
        wait_idle();
        chk(n_start, n_done);
        chans.delete();
        repeat (300) @(posedge clk);
        #1 chk(chans.size(), 0);
        rd(8'h02, 8'h00);
        // one-shot in standby runs enabled channels once
        wr(8'h05, 8'h15);
        wr(8'h0f, 8'ha5);
        wait_starts(1);
        rd(8'h02, 8'h80);
        wait_idle();
        repeat (300) @(posedge clk);
        #1 chk(chans.size(), 3);
        for (int i = 0; i < 3; i++) chk(chans[i], 2 * i);
        // continuous run repeats the same skipped order
        chans.delete();
        wr(8'h04, 8'h00);
        wr(8'h03, 8'h00);
        wait_starts(6);
        for (int i = 0; i < 6; i++) chk(chans[i], 2 * (i % 3));
        // each timed rate with a lone channel, then all five at the long rate
        wr(8'h05, 8'h01);
        for (int r = 1; r < 4; r++) begin
            wr(8'h04, 8'(r));
            wait_starts(3);
            chk(period >= iv[r] && period <= iv[r] + 3, 1);
        end
        wr(8'h05, 8'h1f);
        wait_starts(15);
        chk(period >= iv[3] && period <= iv[3] + 3, 1);
        // mask first, so no channel of the old mask starts late
        wr(8'h05, 8'h01);
        wr(8'h04, 8'h00);
        wait_starts(3);
        chk(period < iv[1], 1);
        // standby in mid-sequence still lets the channel finish
        wr(8'h05, 8'h1f);
        wait_starts(2);
        wr(8'h03, 8'h40);
        wait_idle();
        chans.delete();
        repeat (10) @(posedge clk);
        #1 chk(n_start, n_done);
        chk(chans.size(), 0);
        // a second reset drops every written value back to its default
        wr(8'h05, 8'h0a);
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        rd(8'h03, 8'h03);
        rd(8'h04, 8'h02);
        rd(8'h05, 8'h1f);
        end_sim();
    end
endmodule : conversion_sequence_config_tb_top
